// file: common/acv_params.svh
// Constants for the converter control and output port: offsets, fields, timing.
// Assumes a 100 ns system clock and byte addresses on the register bus.
`ifndef ACV_PARAMS_SVH
`define ACV_PARAMS_SVH

// System clock period and converter phase times in ns
`define ACV_CLK_NS 100
`define ACV_ACQ_NS 1000
`define ACV_CONV_NS 8000
// Least times round up to whole clock cycles
`define ACV_ACQ_CYC ((`ACV_ACQ_NS + `ACV_CLK_NS - 1) / `ACV_CLK_NS)
`define ACV_CONV_CYC ((`ACV_CONV_NS + `ACV_CLK_NS - 1) / `ACV_CLK_NS)
// Half period of the internally made serial clock, in system cycles
`define ACV_SCLK_HALF 2
// Length of the incomplete-read pulse, in system cycles
`define ACV_RDERR_CYC 4

// Register byte offsets
`define ACV_OFS_CTRL 8'h00
`define ACV_OFS_STATUS 8'h04
`define ACV_OFS_MASK 8'h08
`define ACV_OFS_RESULT 8'h0C
`define ACV_OFS_STATE 8'h10

// Control fields
`define ACV_CTRL_PD 0
`define ACV_CTRL_START 1
// Status and mask fields
`define ACV_ST_DONE 0
`define ACV_ST_RDERR 1
`define ACV_ST_RDOK 2

// Shared pin positions in serial mode
`define ACV_PIN_POL 5
`define ACV_PIN_INV 6
`define ACV_PIN_RDC 7
`define ACV_PIN_SDO 8
`define ACV_PIN_SCLK 9
`define ACV_PIN_SYNC 10
`define ACV_PIN_RDERR 11

// Reset level of the synchroniser outputs (active-low strobes idle high)
`define ACV_SYNC_INIT 11'h007

`endif

// file: common/acv_pkg.sv
// Types for the converter control and output port.
// Assumes nothing beyond a SystemVerilog compiler.
package acv_pkg;

	typedef enum logic [1:0] {ST_ACQ, ST_WAIT, ST_CONV, ST_PD} acv_state_t;

endpackage

// file: rtl/acv_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/10ps

module acv_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Raw and filtered levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Shift chain; stage1 feeds only stage2
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Accept a new level per bit once two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					level[i] <= INIT[i];
				end else if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule

// file: rtl/acv_top.sv
// Conversion control, result port and serial link of a 16-bit converter.
// Assumes pins arrive asynchronously, a 10 MHz ref_clk and a classic Wishbone master.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "acv_params.svh"

// Overview of operation
// RULE1: Serial select low drives pins 9..11 as result bits; high gives serial roles.
// RULE2: Serial clock pin is driven out with internal source, input with external.
// RULE3: The invert input picks the serial clock edge that updates data.
// RULE4: Internal clock: frame marker active during read, polarity from polarity input.
// RULE5: External clock: read unfinished at conversion end is lost and flagged by pulse.
// RULE6: Result bits 12..15 are always driven as parallel outputs; the code drives them in both modes, but only while the bus is enabled.
// RULE7: Busy rises at conversion start, falls once result sits in shift register; the code drops it on the edge that latches the result register.
// RULE8: Host may treat busy falling edge as result-ready strobe.
// RULE9: Output bus enabled only while chip select and read strobe are both low.
// RULE10: Reset input high resets logic and aborts a running conversion.
// RULE11: Power-down finishes a running conversion, then blocks new ones.
// RULE12: Start high at end of acquisition: convert on its next falling edge.
// RULE13: Start already low at end of acquisition: hold and convert at once.
// RULE14: External clock: update on rising edge, or falling edge when inverted.
// RULE15: Result leaves the shift register most significant bit first.
// RULE16: Internal clock: read mode high sends during conversion, low after it.
// RULE17: After reset busy is low, bus is off and acquisition begins.
module acv_top
	import acv_pkg::*;
#(
	parameter int ACQ_CYC = `ACV_ACQ_CYC,
	parameter int CONV_CYC = `ACV_CONV_CYC,
	parameter int SCLK_HALF = `ACV_SCLK_HALF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Converter control pins
	input wire logic conversion_start_n,
	input wire logic power_down_input,
	input wire logic converter_reset,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic serial_parallel_select,
	input wire logic serial_clock_source,
	// Code delivered by the approximation core at the end of a conversion
	input wire logic [15:0] sar_code,
	// Shared data pins
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic [15:0] data_oe,
	// Converter status
	output logic busy,
	output logic hold,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Interrupt
	output logic irq
);

	localparam int TMR_W = 8;

	logic [10:0] raw_pins;
	logic [10:0] pins_s;
	logic cnv_s, cs_s, rd_s, pd_s, ser_s, ext_s, ires, pol_s, inv_s, rdc_s, sclk_s;
	acv_state_t state;
	logic [TMR_W-1:0] tmr;
	logic [15:0] result;
	logic cnv_q, cnv_fall, conv_go, conv_done, pd_eff;
	logic ctrl_pd, sw_start;
	logic bus_en, bus_q;
	logic sclk_q, sclk_rise, sclk_fall;
	logic sclk_int;
	logic [3:0] div;
	logic mst, slv, mst_run, mst_act, act_edge;
	logic [15:0] shreg;
	logic [4:0] cnt;
	logic rd_active, start_rd, lost, rd_done;
	logic [15:0] load_val;
	logic [2:0] rderr_cnt;
	logic [2:0] status;
	logic [2:0] mask;
	logic [15:0] next_data;
	logic [15:0] next_oe;
	logic wb_hit, wb_wr;

	// Bring every asynchronous pin into the ref_clk domain
	assign raw_pins = {data_in[`ACV_PIN_SCLK], data_in[`ACV_PIN_RDC], data_in[`ACV_PIN_INV],
		data_in[`ACV_PIN_POL], converter_reset, serial_clock_source, serial_parallel_select,
		power_down_input, read_strobe_n, chip_select_n, conversion_start_n};

	acv_sync #(.W(11), .INIT(`ACV_SYNC_INIT)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(raw_pins),
		.level(pins_s)
	);

	assign {sclk_s, rdc_s, inv_s, pol_s, ires, ext_s, ser_s, pd_s, rd_s, cs_s, cnv_s} = pins_s;

	// Conversion sequencing terms
	assign pd_eff = pd_s | ctrl_pd;
	assign cnv_fall = cnv_q & ~cnv_s;
	assign conv_go = !pd_eff && (((state == ST_ACQ) && (tmr == '0) && (!cnv_s || sw_start))
		|| ((state == ST_WAIT) && (cnv_fall || sw_start)));
	assign conv_done = (state == ST_CONV) && (tmr == '0);

	// Start-pin edge memory
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnv_q <= 1'b1;
		end else begin
			cnv_q <= cnv_s;
		end
	end

	// Acquire, wait, convert and power-down sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ires) begin
			state <= ST_ACQ; // [RULE10] [RULE17]
			tmr <= TMR_W'(ACQ_CYC - 1);
			busy <= 1'b0;
			hold <= 1'b0;
		end else if (conv_go) begin
			state <= ST_CONV; // [RULE12] [RULE13]
			tmr <= TMR_W'(CONV_CYC - 1);
			busy <= 1'b1; // [RULE7]
			hold <= 1'b1;
		end else begin
			unique case (state)
				ST_ACQ: begin
					if (tmr != '0) begin
						tmr <= tmr - 1'b1;
					end else if (pd_eff) begin
						state <= ST_PD; // [RULE11]
					end else begin
						state <= ST_WAIT; // [RULE12]
					end
				end
				ST_WAIT: begin
					if (pd_eff) begin
						state <= ST_PD; // [RULE11]
					end
				end
				ST_CONV: begin
					if (tmr != '0) begin
						tmr <= tmr - 1'b1; // [RULE11]
					end else begin
						state <= ST_ACQ;
						tmr <= TMR_W'(ACQ_CYC - 1);
						busy <= 1'b0; // [RULE7]
						hold <= 1'b0;
					end
				end
				ST_PD: begin
					if (!pd_eff) begin
						state <= ST_ACQ;
						tmr <= TMR_W'(ACQ_CYC - 1);
					end
				end
			endcase
		end
	end

	// Latch the finished code in the same edge that drops busy
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			result <= '0;
		end else if (conv_done && !ires) begin
			result <= sar_code; // [RULE7]
		end
	end

	// Serial clock edges, bus enable and master clock phase
	assign bus_en = !(cs_s | rd_s); // [RULE9]
	assign sclk_rise = sclk_s & ~sclk_q;
	assign sclk_fall = ~sclk_s & sclk_q;
	assign mst = ser_s & ~ext_s;
	assign slv = ser_s & ext_s;
	assign mst_run = rd_active || (sclk_int != inv_s);
	assign mst_act = mst && mst_run && (div == '0) && (sclk_int == inv_s);
	assign act_edge = mst ? mst_act : (slv && (inv_s ? sclk_fall : sclk_rise)); // [RULE3] [RULE14]

	// Read starts: after or during conversion with own clock, on selection otherwise
	assign start_rd = !rd_active && (mst ? (rdc_s ? conv_go : conv_done)
		: (slv && bus_en && !bus_q)); // [RULE16]
	assign load_val = conv_done ? sar_code : result;
	assign lost = slv && rd_active && conv_done; // [RULE5]
	assign rd_done = act_edge && rd_active && (cnt == 5'd1);

	// Edge history of the host clock and the enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			bus_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			bus_q <= bus_en;
		end
	end

	// Internal serial clock divider; idles at the invert level
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sclk_int <= 1'b0;
			div <= '0;
		end else if (!mst) begin
			sclk_int <= inv_s;
			div <= '0;
		end else if (mst_run) begin
			if (div == '0) begin
				sclk_int <= ~sclk_int;
				div <= 4'(SCLK_HALF - 1);
			end else begin
				div <= div - 1'b1;
			end
		end
	end

	// Shift register: first active edge shows the top bit, later ones shift left
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ires || !ser_s) begin
			shreg <= '0;
			cnt <= '0;
			rd_active <= 1'b0;
		end else if (lost) begin
			cnt <= '0; // [RULE5]
			rd_active <= 1'b0;
		end else if (start_rd) begin
			shreg <= load_val;
			cnt <= 5'd16;
			rd_active <= 1'b1;
		end else if (act_edge && rd_active) begin
			if (cnt != 5'd16) begin
				shreg <= {shreg[14:0], 1'b0}; // [RULE15]
			end
			cnt <= cnt - 1'b1;
			if (cnt == 5'd1) begin
				rd_active <= 1'b0;
			end
		end
	end

	// Incomplete-read pulse stretcher
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ires) begin
			rderr_cnt <= '0;
		end else if (lost) begin
			rderr_cnt <= 3'(`ACV_RDERR_CYC); // [RULE5]
		end else if (rderr_cnt != '0) begin
			rderr_cnt <= rderr_cnt - 1'b1;
		end
	end

	// Pin values and enables for parallel or serial use
	always_comb begin
		next_data = '0;
		next_oe = '0;
		next_data[15:12] = result[15:12]; // [RULE6]
		next_oe[15:12] = {4{bus_en}}; // [RULE6] [RULE9]
		if (!ser_s) begin
			next_data[11:0] = result[11:0]; // [RULE1]
			next_oe[11:0] = {12{bus_en}}; // [RULE1] [RULE9]
		end else begin
			next_data[`ACV_PIN_SDO] = shreg[15]; // [RULE15]
			next_oe[`ACV_PIN_SDO] = bus_en; // [RULE9]
			next_data[`ACV_PIN_SCLK] = sclk_int;
			next_oe[`ACV_PIN_SCLK] = ~ext_s; // [RULE2]
			next_data[`ACV_PIN_SYNC] = mst_run ^ pol_s; // [RULE4]
			next_oe[`ACV_PIN_SYNC] = ~ext_s; // [RULE4]
			next_data[`ACV_PIN_RDERR] = (rderr_cnt != '0);
			next_oe[`ACV_PIN_RDERR] = ext_s; // [RULE5]
		end
	end

	// Register the pins so they change only on ref_clk
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			data_out <= '0;
			data_oe <= '0; // [RULE17]
		end else begin
			data_out <= next_data;
			data_oe <= next_oe;
		end
	end

	// Wishbone handshake: ack one cycle after the strobe, dropped the next
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= '0;
			if (wb_hit && !wb_we_i) begin
				unique case (wb_adr_i)
					`ACV_OFS_CTRL: wb_dat_o <= {30'h0000_0000, 1'b0, ctrl_pd};
					`ACV_OFS_STATUS: wb_dat_o <= {29'h0000_0000, status};
					`ACV_OFS_MASK: wb_dat_o <= {29'h0000_0000, mask};
					`ACV_OFS_RESULT: wb_dat_o <= {16'h0000, result};
					`ACV_OFS_STATE: wb_dat_o <= {28'h0000_000, state == ST_WAIT,
						state == ST_PD, rd_active, busy};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	// Control register; the start bit is a self-clearing one-cycle request
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_pd <= 1'b0;
			sw_start <= 1'b0;
		end else begin
			sw_start <= wb_wr && (wb_adr_i == `ACV_OFS_CTRL) && wb_dat_i[`ACV_CTRL_START];
			if (wb_wr && (wb_adr_i == `ACV_OFS_CTRL)) begin
				ctrl_pd <= wb_dat_i[`ACV_CTRL_PD];
			end
		end
	end

	// Sticky events; a new event beats a write-one clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status <= '0;
			mask <= '0;
			irq <= 1'b0;
		end else begin
			if (wb_wr && (wb_adr_i == `ACV_OFS_STATUS)) begin
				status <= (status & ~wb_dat_i[2:0]) | {rd_done, lost, conv_done};
			end else begin
				status <= status | {rd_done, lost, conv_done};
			end
			if (wb_wr && (wb_adr_i == `ACV_OFS_MASK)) begin
				mask <= wb_dat_i[2:0];
			end
			irq <= |(status & mask);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_wait_edge;
		(state == ST_WAIT) && cnv_fall && !pd_eff && !ires;
	endsequence

	sequence s_read_lost;
		lost && !ires;
	endsequence

	a_par_shared_bits: assert property (!ser_s && bus_en |=> // [RULE1]
		data_out[11:9] == $past(result[11:9]) && data_oe[11:9] == 3'h7)
		else $error("Parallel bits 9 to 11 not driven");
	a_sclk_dir: assert property (ser_s |=> data_oe[`ACV_PIN_SCLK] == !$past(ext_s)) // [RULE2]
		else $error("Serial clock direction wrong");
	a_slave_edge: assert property (ser_s && ext_s && $past(rd_active) && rd_active // [RULE14]
		&& $changed(shreg) |-> $past(inv_s ? sclk_fall : sclk_rise))
		else $error("Serial data moved on the wrong edge");
	a_sync_level: assert property (ser_s && !ext_s && mst_run |=> // [RULE4]
		data_out[`ACV_PIN_SYNC] == !$past(pol_s))
		else $error("Frame marker level wrong");
	a_rderr_pulse: assert property (s_read_lost |=> (rderr_cnt != '0)[*4] ##1 // [RULE5]
		(rderr_cnt == '0 || $past(lost)))
		else $error("Incomplete-read pulse length wrong");
	a_high_nibble: assert property (bus_en |=> data_oe[15:12] == 4'hF) // [RULE6]
		else $error("High result bits not driven");
	a_busy_end: assert property ($fell(busy) && !$past(ires) |-> // [RULE7]
		$past(state) == ST_CONV && result == $past(sar_code))
		else $error("Busy fell before result was latched");
	a_bus_enable: assert property (data_oe[`ACV_PIN_SDO] |-> $past(bus_en)) // [RULE9]
		else $error("Output enabled without select and read");
	a_reset_abort: assert property (ires |=> state == ST_ACQ && !busy && !hold) // [RULE10]
		else $error("Reset input did not abort");
	a_pd_finish: assert property ((state == ST_CONV) && (tmr != '0) && !ires |=> // [RULE11]
		state == ST_CONV)
		else $error("Conversion cut short");
	a_pd_block: assert property ((state == ST_WAIT) && pd_eff && !ires |=> // [RULE11]
		state == ST_PD ##1 !busy)
		else $error("Power-down did not block conversion");
	a_wait_start: assert property (s_wait_edge |=> state == ST_CONV && busy && hold) // [RULE12]
		else $error("Falling start edge did not start conversion");
	a_acq_immediate: assert property ((state == ST_ACQ) && (tmr == '0) && !cnv_s // [RULE13]
		&& !pd_eff && !ires |=> busy && hold)
		else $error("Low start did not convert at once");
	a_shift_msb: assert property (act_edge && rd_active && (cnt != 5'd16) && !lost // [RULE15]
		&& ser_s && !ires |=> shreg == {$past(shreg[14:0]), 1'b0})
		else $error("Shift not most significant first");
	a_rd_after: assert property (mst && !rdc_s && conv_done && !rd_active && !ires |=> // [RULE16]
		rd_active && shreg == $past(sar_code))
		else $error("Read after conversion did not start");
	a_reset_state: assert property ($rose(rst_n) |-> state == ST_ACQ && !busy // [RULE17]
		&& data_oe == 16'h0000)
		else $error("Bad state after reset");

endmodule

// file: sim/acv_host.sv
// Host model on the far side of the pins: pin return path, host serial clock and capture.
// Assumes the bench drives strobes and start; device pins come in registered.
`timescale 1ns/10ps

module acv_host (
	// Clock
	input wire logic ref_clk,
	// Device pins
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	output logic [15:0] data_in
);
	logic [15:0] drv = 16'h0000;
	logic [15:0] cap = 16'h0000;
	logic noise = 1'b0;
	logic pclk;
	logic pfr;
	int ncap = 0;

	// Released pins toggle so a stale level never passes for data
	always @(posedge ref_clk) noise <= ~noise;
	assign data_in = (data_oe & data_out)
		| (~data_oe & ((drv & 16'h02e0) | ({16{noise}} & ~16'h02e0)));

	// Device clock: take data on each return to idle while the frame is on
	// Only the pin levels are seen, so a disabled data pin shows noise
	always @(posedge ref_clk) begin
		pclk <= data_in[9];
		pfr <= data_in[10] ^ drv[5];
		if (pfr && pclk !== drv[6] && data_in[9] === drv[6]) begin
			cap <= {cap[14:0], data_in[8]};
			ncap <= ncap + 1;
		end
	end

	// Host clock read: settle, then n periods of 800 ns, data taken before each next edge
	task automatic sread(input int n, output logic [15:0] w);
		w = 16'h0000;
		repeat (20) @(posedge ref_clk);
		for (int b = 0; b < n; b++) begin
			drv[9] <= ~drv[6];
			repeat (4) @(posedge ref_clk);
			drv[9] <= drv[6];
			repeat (4) @(posedge ref_clk);
			w = {w[14:0], data_in[8]};
		end
	endtask
endmodule

// file: sim/tb_adc_conversion_output_interface.sv
// Self-checking bench for the converter control and output port.
// Assumes the host model on the pins and short acquisition and conversion counts.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end

module tb_adc_conversion_output_interface
	import acv_pkg::*;
;
	localparam int ACQ = 4;
	localparam int CONV = 12;
	logic ref_clk = 1'b0, rst_n = 1'b0, start_n = 1'b1, pd = 1'b0, crst = 1'b0;
	logic cs_n = 1'b1, rd_n = 1'b1, sps = 1'b0, src = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack_o, busy, hold, irq;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, r;
	logic [15:0] sar_code = 16'h0000, data_in, data_out, data_oe, last = 16'h0000, code, w;
	int failures = 0, total_checks = 0, cyc = 0, nflag = 0, n;

	acv_top #(.ACQ_CYC(ACQ), .CONV_CYC(CONV), .SCLK_HALF(2)) i_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .conversion_start_n(start_n), .power_down_input(pd),
		.converter_reset(crst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
		.serial_parallel_select(sps), .serial_clock_source(src), .sar_code(sar_code),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy(busy), .hold(hold),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
	acv_host i_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));

	// Clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	// Hang limit and length of the lost-read pulse
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (data_oe[11] && data_out[11]) nflag <= nflag + 1;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end

	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			failures++;
			$display("BAD wb ack expected 1 seen %b", wb_ack_o);
		end
		r = wb_dat_o;
		wb_cyc <= 1'b0; wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Wait for busy to reach a level; n counts the edges
	task automatic waitb(input logic lvl);
		n = 0;
		while (busy !== lvl && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	// One conversion started by a pulse on the start pin
	task automatic conv(input logic [15:0] c);
		sar_code <= c;
		start_n <= 1'b0;
		waitb(1'b1);
		`CHK("hold", 1'b1, hold)
		start_n <= 1'b1;
		waitb(1'b0);
		`CHK("busy length", CONV, n)
		last = c;
	endtask

	task automatic done(input string s);
		$display("Test %s ended, %0d mismatches so far", s, failures);
	endtask

	task automatic give_verdict();
		$display("Checks made %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h95fe_ab4c));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		`CHK("oe after reset", 16'h0000, data_oe)
		`CHK("busy after reset", 1'b0, busy)
		wb(1'b0, 8'h14, 32'h0000_0000);
		`CHK("unmapped read", 32'h0000_0000, r)
		done("reset");
		// Parallel reads; chip select alone must not open the bus
		repeat (4) begin
			code = 16'($urandom);
			conv(code);
			cs_n <= 1'b0;
			repeat (8) @(posedge ref_clk);
			`CHK("oe cs only", 16'h0000, data_oe)
			rd_n <= 1'b0;
			repeat (8) @(posedge ref_clk);
			`CHK("oe read", 16'hffff, data_oe)
			`CHK("parallel data", code, data_out)
			wb(1'b0, 8'h0c, 32'h0000_0000);
			`CHK("result reg", {16'h0000, code}, r)
			cs_n <= 1'b1; rd_n <= 1'b1;
		end
		// Interrupt: masked, unmasked, then cleared by writing one
		`CHK("irq masked", 1'b0, irq)
		wb(1'b1, 8'h08, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		`CHK("irq on", 1'b1, irq)
		wb(1'b1, 8'h04, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		`CHK("irq off", 1'b0, irq)
		done("parallel");
		// Start held high past acquisition: convert on its falling edge
		repeat (ACQ + 20) @(posedge ref_clk);
		`CHK("idle busy", 1'b0, busy)
		wb(1'b0, 8'h10, 32'h0000_0000);
		`CHK("waiting state", 1'b1, r[3])
		start_n <= 1'b0;
		waitb(1'b1);
		`CHK("edge start", 1'b1, n < 8)
		start_n <= 1'b1;
		waitb(1'b0);
		done("start edge");
		// Power-down mid conversion: it completes, then nothing starts
		code = 16'($urandom);
		sar_code <= code;
		start_n <= 1'b0;
		waitb(1'b1);
		pd <= 1'b1;
		waitb(1'b0);
		`CHK("pd finish", CONV, n)
		last = code;
		repeat (40) @(posedge ref_clk);
		`CHK("pd no start", 1'b0, busy)
		wb(1'b0, 8'h10, 32'h0000_0000);
		`CHK("pd state", 1'b1, r[2])
		pd <= 1'b0;
		waitb(1'b1);
		start_n <= 1'b1;
		waitb(1'b0);
		// Converter reset aborts: busy drops early, result untouched
		sar_code <= ~last;
		start_n <= 1'b0;
		waitb(1'b1);
		start_n <= 1'b1;
		crst <= 1'b1;
		waitb(1'b0);
		`CHK("abort fast", 1'b1, n < 8)
		crst <= 1'b0;
		wb(1'b0, 8'h0c, 32'h0000_0000);
		`CHK("abort result", {16'h0000, last}, r)
		done("power and reset");
		// Host-clocked serial reads in both clock senses
		sps <= 1'b1;
		src <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			i_host.drv[6] = k[0];
			i_host.drv[9] = k[0];
			repeat (8) @(posedge ref_clk);
			code = 16'($urandom);
			conv(code);
			cs_n <= 1'b0; rd_n <= 1'b0;
			i_host.sread(16, w);
			@(posedge ref_clk);
			`CHK("serial oe", 8'hf9, data_oe[15:8])
			`CHK("serial word", code, w)
			`CHK("high bits", code[15:12], data_out[15:12])
			cs_n <= 1'b1; rd_n <= 1'b1;
		end
		// Read left unfinished when the next conversion ends
		conv(code);
		cs_n <= 1'b0; rd_n <= 1'b0;
		i_host.sread(4, w);
		@(posedge ref_clk);
		nflag = 0;
		conv(~code);
		repeat (8) @(posedge ref_clk);
		`CHK("lost read pulse", 4, nflag)
		wb(1'b0, 8'h04, 32'h0000_0000);
		`CHK("lost read status", 1'b1, r[1])
		`CHK("read done status", 1'b1, r[2])
		done("host clock");
		// Device-clocked reads over read mode, marker polarity and clock sense
		src <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			i_host.drv[5] = k[0];
			i_host.drv[7] = k[1];
			i_host.drv[6] = k[0] ^ k[1];
			repeat (8) @(posedge ref_clk);
			i_host.ncap = 0;
			w = last;
			code = 16'($urandom);
			cs_n <= 1'b0; rd_n <= 1'b0;
			conv(code);
			repeat (90) @(posedge ref_clk);
			`CHK("bit count", 16, i_host.ncap)
			`CHK("device word", k[1] ? w : code, i_host.cap)
			`CHK("marker idle", k[0], data_out[10])
			cs_n <= 1'b1; rd_n <= 1'b1;
		end
		done("device clock");
		give_verdict();
	end
endmodule
